// >>> core/mhsp_defs.vh
/*
  Constants of the monitor host serial port: clock rate, bus addresses,
  CRC code, frame lengths, answer patterns and timing figures.
  Assumes inclusion by bare name from every design file of the block.
*/
`ifndef MHSP_DEFS_VH
`define MHSP_DEFS_VH

// ***********************************************************************
// clock and time conversion
// ***********************************************************************
`define MHSP_CLK_MHZ        200
`define MHSP_MS_CYC(ms)     ((ms) * `MHSP_CLK_MHZ * 1000)
`define MHSP_US_CYC(us)     ((us) * `MHSP_CLK_MHZ)

// ***********************************************************************
// timing figures
// ***********************************************************************
`define MHSP_T_LOW100_MS    25
`define MHSP_T_EXT100_MS    10
`define MHSP_T_LOW400_MS    5
`define MHSP_T_LONG_MS      2000
`define MHSP_T_STALL_MS     2000
`define MHSP_T_SEC_MS       1000
`define MHSP_T_WAKE_US      50
`define MHSP_T_INPUT_FILTER_ENABLE_NS      200
`define MHSP_INPUT_FILTER_ENABLE_CYC       ((`MHSP_T_INPUT_FILTER_ENABLE_NS * `MHSP_CLK_MHZ) / 1000)

// ***********************************************************************
// two-wire bus
// ***********************************************************************
`define MHSP_I2C_ADDR       8'h10
`define MHSP_RST_FAST       1'b1

// ***********************************************************************
// crc code
// ***********************************************************************
`define MHSP_CRC_POLY       8'h07
`define MHSP_CRC_INIT       8'h00

// ***********************************************************************
// four-wire frames and answer patterns
// ***********************************************************************
`define MHSP_SPI_LEN_PLAIN  5'd16
`define MHSP_SPI_LEN_CRC    5'd24
`define MHSP_SPI_ONES       16'hFFFF
`define MHSP_SPI_CRC_ERR    8'hAA
`define MHSP_SPI_STALE_CRC  8'h00
`define MHSP_SPI_NOOSC      24'hFFFFFF
`define MHSP_IDLE_MIN_S     8'h01

`endif

// >>> core/mhsp_pin_filter.v
/*
  One input pin: two-flop synchroniser followed by an optional delay
  line that stands in for the analog pin filter.
  Assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "mhsp_defs.vh"

module mhsp_pin_filter #(
  parameter RST_VAL = 1'b0
) (
  input  wire ref_clk,
  input  wire rst_b,
  input  wire pinIn,
  input  wire filtEn,
  output wire pinOut
);

  reg                       meta_reg;
  reg                       sync_reg;
  reg [`MHSP_INPUT_FILTER_ENABLE_CYC-1:0]  dly_reg;
  reg                       out_reg;

  assign pinOut = out_reg;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
      dly_reg  <= {`MHSP_INPUT_FILTER_ENABLE_CYC{RST_VAL}};
      out_reg  <= RST_VAL;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      dly_reg  <= {dly_reg[`MHSP_INPUT_FILTER_ENABLE_CYC-2:0], sync_reg};
      out_reg  <= filtEn ? dly_reg[`MHSP_INPUT_FILTER_ENABLE_CYC-1] : sync_reg;
    end
  end

endmodule

// >>> core/mhsp_serial_port.v
/*
  Host serial port: two-wire slave with auto-increment and timeouts,
  four-wire mode-0 slave with fixed frames, optional CRC on both.
  Assumes pins are asynchronous, all cfg inputs and the register side
  run on ref_clk; register read data is valid one cycle after a strobe.
*/
// Functional notes
// RULE_01 - two-wire side is slave only, 100 kHz or 400 kHz by config
// RULE_02 - slave address 0x10 write, 0x11 read unless config overrides
// RULE_03 - 100 kHz timeouts: clock low 25 ms, master stretch total 10 ms
// RULE_04 - 400 kHz timeout: clock held low past 5 ms resets the slave
// RULE_05 - clock low over 2 s always resets the slave
// RULE_06 - block writes allowed; address increments after each data byte
// RULE_07 - write crc: first byte covers address bytes, later only data
// RULE_08 - crc is x^8+x^2+x+1 starting from zero
// RULE_09 - bad write crc gets not-acknowledge, slave goes idle
// RULE_10 - read crc runs from first start, restarts per byte and stop
// RULE_11 - master acks all but last byte; its nack sends slave idle
// RULE_12 - speed change applies on update exit; swap command is instant
// RULE_13 - protocol change waits for reset or four-wire swap command
// RULE_14 - four-wire side uses clock polarity 0, phase 0
// RULE_15 - frames are 16 bits, 24 with crc; other counts flag error
// RULE_16 - bad four-wire crc drops data, answers 0xFFFF then crc 0xAA
// RULE_17 - oscillator down at frame start: shift out all ones
// RULE_18 - chip-select fall wakes oscillator, usable after 50 us
// RULE_19 - all-ones first two bytes never taken as a write
// RULE_20 - oscillator held for idle seconds, zero means one second
// RULE_21 - select low with frozen clock for 2 s resets four-wire logic
// RULE_22 - optional 200 ns input filter, on unless cleared
// RULE_23 - first byte direction then 7-bit address, msb first
// RULE_24 - host sends third byte crc over first two bytes
// RULE_25 - buffer not refreshed: answer 0xFFFF with crc 0x00
`timescale 1ns/1ps
`include "mhsp_defs.vh"

module mhsp_serial_port #(
  parameter LONG_CYC   = `MHSP_MS_CYC(`MHSP_T_LONG_MS),
  parameter LOW100_CYC = `MHSP_MS_CYC(`MHSP_T_LOW100_MS),
  parameter EXT100_CYC = `MHSP_MS_CYC(`MHSP_T_EXT100_MS),
  parameter LOW400_CYC = `MHSP_MS_CYC(`MHSP_T_LOW400_MS),
  parameter STALL_CYC  = `MHSP_MS_CYC(`MHSP_T_STALL_MS),
  parameter SEC_CYC    = `MHSP_MS_CYC(`MHSP_T_SEC_MS),
  parameter WAKE_CYC   = `MHSP_US_CYC(`MHSP_T_WAKE_US)
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        i2cScl,
  input  wire        i2cSdaIn,
  output wire        i2cSdaOut,
  output wire        i2cSdaOe,
  input  wire        spiSclk,
  input  wire        spiCs_b,
  input  wire        spiMosi,
  output wire        spiMiso,
  output wire        spiMisoOe,
  input  wire        cfgProtoSpi,
  input  wire        cfgFastMode,
  input  wire        cfgTimeoutEn,
  input  wire        cfgAddrOverride,
  input  wire [7:0]  cfgSlaveAddr,
  input  wire        cfgCrcEn,
  input  wire        input_filter_enable,
  input  wire [7:0]  cfgIdleTime,
  input  wire        cfgMisoAux,
  input  wire        cfgUpdateMode,
  input  wire        switch_to_two_wire_cmd,
  input  wire        switch_to_four_wire_cmd,
  input  wire        oscRunning,
  output wire        oscRequest,
  output wire        output_from_aux_regulator,
  output wire        activeSpi,
  output wire        fastModeActive,
  output wire        regRdStb,
  output wire        regWrStb,
  output wire [7:0]  regAddr,
  output wire [7:0]  regWrData,
  input  wire [7:0]  regRdData,
  output wire        spiInValid,
  output wire        spiInWrite,
  output wire [6:0]  spiInAddr,
  output wire [7:0]  spiInData,
  input  wire        spiOutLoad,
  input  wire [15:0] spiOutWord,
  output wire        i2cBusReset,
  output wire        spiFrameErr,
  output wire        spiCrcErr,
  output wire        spiBusReset
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_REG  = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_WCRC = 3'd4;
  localparam ST_RDAT = 3'd5;
  localparam ST_RCRC = 3'd6;
  localparam ST_IGN  = 3'd7;

  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer     i;
    reg   [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1)
        r = r[7] ? ({r[6:0], 1'b0} ^ `MHSP_CRC_POLY) : {r[6:0], 1'b0};
      crc8 = r;
    end
  endfunction

  // ***********************************************************************
  // pin synchronisers and filters
  // ***********************************************************************
  wire sclS, sdaS, sclkS, csS, mosiS, oscS;

  mhsp_pin_filter #(.RST_VAL(1'b1)) uScl (.ref_clk(ref_clk), .rst_b(rst_b),
    .pinIn(i2cScl), .filtEn(1'b0), .pinOut(sclS));
  mhsp_pin_filter #(.RST_VAL(1'b1)) uSda (.ref_clk(ref_clk), .rst_b(rst_b),
    .pinIn(i2cSdaIn), .filtEn(1'b0), .pinOut(sdaS));
  mhsp_pin_filter #(.RST_VAL(1'b0)) uSclk (.ref_clk(ref_clk), .rst_b(rst_b),
    .pinIn(spiSclk), .filtEn(input_filter_enable), .pinOut(sclkS)); // [RULE_22]
  mhsp_pin_filter #(.RST_VAL(1'b1)) uCs (.ref_clk(ref_clk), .rst_b(rst_b),
    .pinIn(spiCs_b), .filtEn(input_filter_enable), .pinOut(csS)); // [RULE_22]
  mhsp_pin_filter #(.RST_VAL(1'b0)) uMosi (.ref_clk(ref_clk), .rst_b(rst_b),
    .pinIn(spiMosi), .filtEn(input_filter_enable), .pinOut(mosiS)); // [RULE_22]
  mhsp_pin_filter #(.RST_VAL(1'b0)) uOsc (.ref_clk(ref_clk), .rst_b(rst_b),
    .pinIn(oscRunning), .filtEn(1'b0), .pinOut(oscS));

  // ***********************************************************************
  // interface selection and speed
  // ***********************************************************************
  reg loaded_reg, activeSpi_reg, fast_reg, misoAux_reg, updD_reg;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loaded_reg    <= 1'b0;
      activeSpi_reg <= 1'b0;
      fast_reg      <= `MHSP_RST_FAST;
      misoAux_reg   <= 1'b0;
      updD_reg      <= 1'b0;
    end else begin
      updD_reg <= cfgUpdateMode;
      if (!loaded_reg) begin
        loaded_reg    <= 1'b1;
        activeSpi_reg <= cfgProtoSpi; // [RULE_13]
        fast_reg      <= cfgFastMode;
        misoAux_reg   <= cfgMisoAux;
      end else begin
        if (switch_to_four_wire_cmd) begin
          activeSpi_reg <= 1'b1; // [RULE_13]
          misoAux_reg   <= cfgMisoAux;
        end else if (switch_to_two_wire_cmd) begin
          activeSpi_reg <= 1'b0; // [RULE_12]
        end
        if (updD_reg && !cfgUpdateMode)
          fast_reg <= cfgFastMode; // [RULE_12] [RULE_01]
      end
    end
  end

  assign activeSpi                 = activeSpi_reg;
  assign fastModeActive            = fast_reg;
  assign output_from_aux_regulator = misoAux_reg;

  // ***********************************************************************
  // two-wire slave
  // ***********************************************************************
  reg [2:0]  st_reg;
  reg [3:0]  bit_reg;
  reg [7:0]  sh_reg, tx_reg, crc_reg, ptr_reg, dat_reg;
  reg [7:0]  busAddr_reg, wrData_reg;
  reg        sdaLow_reg, rxAck_reg, ackOk_reg, rdWait_reg;
  reg        rdStb_reg, wrStb_reg, i2cRst_reg, sclD_reg, sdaD_reg;
  reg [31:0] lowCnt_reg, cumCnt_reg;

  wire i2cRun    = loaded_reg && !activeSpi_reg;
  wire sclRise   = sclS && !sclD_reg;
  wire sclFall   = !sclS && sclD_reg;
  wire startCond = sclS && sclD_reg && sdaD_reg && !sdaS;
  wire stopCond  = sclS && sclD_reg && !sdaD_reg && sdaS;
  wire txState   = (st_reg == ST_RDAT) || (st_reg == ST_RCRC);
  wire [7:0] myAddr = cfgAddrOverride ? cfgSlaveAddr : `MHSP_I2C_ADDR;
  wire i2cTmo = i2cRun && ((lowCnt_reg >= LONG_CYC) // [RULE_05]
    || (cfgTimeoutEn && (fast_reg ? (lowCnt_reg >= LOW400_CYC) // [RULE_04]
    : (lowCnt_reg >= LOW100_CYC || cumCnt_reg >= EXT100_CYC)))); // [RULE_03]

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_IDLE;      bit_reg <= 4'h0;       sh_reg <= 8'h00;
      tx_reg <= 8'hFF;        crc_reg <= `MHSP_CRC_INIT;
      ptr_reg <= 8'h00;       dat_reg <= 8'h00;      busAddr_reg <= 8'h00;
      wrData_reg <= 8'h00;    sdaLow_reg <= 1'b0;    rxAck_reg <= 1'b0;
      ackOk_reg <= 1'b0;      rdWait_reg <= 1'b0;    rdStb_reg <= 1'b0;
      wrStb_reg <= 1'b0;      i2cRst_reg <= 1'b0;    sclD_reg <= 1'b1;
      sdaD_reg <= 1'b1;       lowCnt_reg <= 32'h0;   cumCnt_reg <= 32'h0;
    end else begin
      sclD_reg   <= sclS;
      sdaD_reg   <= sdaS;
      rdStb_reg  <= 1'b0;
      wrStb_reg  <= 1'b0;
      i2cRst_reg <= 1'b0;
      rdWait_reg <= rdStb_reg;
      lowCnt_reg <= (sclS || lowCnt_reg >= LONG_CYC) ? 32'h0
                    : lowCnt_reg + 32'd1;
      if (st_reg != ST_IDLE && !sclS)
        cumCnt_reg <= cumCnt_reg + 32'd1;
      if (!i2cRun || i2cTmo) begin
        st_reg     <= ST_IDLE;
        sdaLow_reg <= 1'b0;
        i2cRst_reg <= i2cTmo;
        lowCnt_reg <= 32'h0;
        cumCnt_reg <= 32'h0;
      end else if (startCond) begin
        if (st_reg == ST_IDLE)
          crc_reg <= `MHSP_CRC_INIT; // [RULE_10]
        st_reg     <= ST_ADDR;
        bit_reg    <= 4'h0;
        rxAck_reg  <= 1'b0;
        sdaLow_reg <= 1'b0;
        cumCnt_reg <= 32'h0;
      end else if (stopCond) begin
        st_reg     <= ST_IDLE;
        sdaLow_reg <= 1'b0;
        crc_reg    <= `MHSP_CRC_INIT; // [RULE_10]
        cumCnt_reg <= 32'h0;
      end else if (rdWait_reg && st_reg == ST_RDAT) begin
        tx_reg     <= regRdData;
        sdaLow_reg <= !regRdData[7];
        crc_reg    <= crc8(crc_reg, regRdData); // [RULE_10]
      end else if (sclRise && st_reg != ST_IDLE && bit_reg != 4'd9) begin
        bit_reg <= bit_reg + 4'd1;
        if (bit_reg < 4'd8)
          sh_reg <= {sh_reg[6:0], sdaS};
        else
          ackOk_reg <= !sdaS;
      end else if (sclFall && st_reg != ST_IDLE) begin
        if (bit_reg == 4'd8 && !txState) begin
          rxAck_reg  <= 1'b1;
          bit_reg    <= 4'd9;
          sdaLow_reg <= 1'b1;
          case (st_reg)
            ST_ADDR: begin
              if (sh_reg[7:1] == myAddr[7:1]) begin // [RULE_02]
                crc_reg <= crc8(crc_reg, sh_reg);
                st_reg  <= sh_reg[0] ? ST_RDAT : ST_REG;
              end else begin
                sdaLow_reg <= 1'b0;
                st_reg     <= ST_IGN;
              end
            end
            ST_REG: begin
              ptr_reg <= sh_reg;
              crc_reg <= crc8(crc_reg, sh_reg); // [RULE_07]
              st_reg  <= ST_WDAT;
            end
            ST_WDAT: begin
              if (cfgCrcEn) begin
                dat_reg <= sh_reg;
                crc_reg <= crc8(crc_reg, sh_reg); // [RULE_07] [RULE_08]
                st_reg  <= ST_WCRC;
              end else begin
                wrStb_reg   <= 1'b1;
                busAddr_reg <= ptr_reg;
                wrData_reg  <= sh_reg;
                ptr_reg     <= ptr_reg + 8'd1; // [RULE_06]
              end
            end
            ST_WCRC: begin
              if (sh_reg == crc_reg) begin
                wrStb_reg   <= 1'b1;
                busAddr_reg <= ptr_reg;
                wrData_reg  <= dat_reg;
                ptr_reg     <= ptr_reg + 8'd1; // [RULE_06]
                crc_reg     <= `MHSP_CRC_INIT; // [RULE_07]
                st_reg      <= ST_WDAT;
              end else begin
                sdaLow_reg <= 1'b0; // [RULE_09]
                st_reg     <= ST_IDLE;
              end
            end
            default: begin
              sdaLow_reg <= 1'b0;
            end
          endcase
        end else if (bit_reg == 4'd8) begin
          sdaLow_reg <= 1'b0;
          if (st_reg == ST_RDAT)
            ptr_reg <= ptr_reg + 8'd1; // [RULE_06]
        end else if (bit_reg == 4'd9) begin
          bit_reg   <= 4'h0;
          rxAck_reg <= 1'b0;
          if (rxAck_reg) begin
            sdaLow_reg <= 1'b0;
            if (st_reg == ST_RDAT) begin
              rdStb_reg   <= 1'b1;
              busAddr_reg <= ptr_reg;
            end
          end else if (!ackOk_reg) begin
            sdaLow_reg <= 1'b0;
            st_reg     <= ST_IDLE; // [RULE_11]
          end else if (st_reg == ST_RDAT && cfgCrcEn) begin
            st_reg     <= ST_RCRC;
            tx_reg     <= crc_reg;
            sdaLow_reg <= !crc_reg[7];
          end else begin
            crc_reg     <= `MHSP_CRC_INIT; // [RULE_10]
            st_reg      <= ST_RDAT;
            rdStb_reg   <= 1'b1;
            busAddr_reg <= ptr_reg;
          end
        end else if (txState && bit_reg != 4'h0) begin
          tx_reg     <= {tx_reg[6:0], 1'b1};
          sdaLow_reg <= !tx_reg[6];
        end
      end
    end
  end

  assign i2cSdaOut   = 1'b0;
  assign i2cSdaOe    = sdaLow_reg;
  assign regRdStb    = rdStb_reg;
  assign regWrStb    = wrStb_reg;
  assign regAddr     = busAddr_reg;
  assign regWrData   = wrData_reg;
  assign i2cBusReset = i2cRst_reg;

  // ***********************************************************************
  // oscillator wake and hold
  // ***********************************************************************
  reg        oscReq_reg;
  reg [31:0] secCnt_reg, wakeCnt_reg, stallCnt_reg;
  reg [7:0]  secLeft_reg;
  reg        csD_reg, sclkD_reg;

  wire spiRun  = loaded_reg && activeSpi_reg;
  wire csFall  = csD_reg && !csS;
  wire csRise  = !csD_reg && csS;
  wire oscRdy  = oscReq_reg && (wakeCnt_reg >= WAKE_CYC); // [RULE_18]

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscReq_reg  <= 1'b0;
      secCnt_reg  <= 32'h0;
      wakeCnt_reg <= 32'h0;
      secLeft_reg <= 8'h00;
    end else begin
      if (!oscReq_reg || !oscS)
        wakeCnt_reg <= 32'h0;
      else if (wakeCnt_reg < WAKE_CYC)
        wakeCnt_reg <= wakeCnt_reg + 32'd1;
      if (spiRun && csFall) begin
        oscReq_reg  <= 1'b1; // [RULE_18]
        secCnt_reg  <= 32'h0;
        secLeft_reg <= (cfgIdleTime == 8'h00) ? `MHSP_IDLE_MIN_S
                       : cfgIdleTime; // [RULE_20]
      end else if (oscReq_reg && csS) begin
        if (secCnt_reg >= SEC_CYC - 1) begin
          secCnt_reg <= 32'h0;
          if (secLeft_reg <= `MHSP_IDLE_MIN_S)
            oscReq_reg <= 1'b0; // [RULE_20]
          else
            secLeft_reg <= secLeft_reg - 8'd1;
        end else begin
          secCnt_reg <= secCnt_reg + 32'd1;
        end
      end
    end
  end

  assign oscRequest = oscReq_reg;

  // ***********************************************************************
  // four-wire slave
  // ***********************************************************************
  reg        on_reg, miso_reg, fresh_reg, inVal_reg, frErr_reg;
  reg        crcErr_reg, spiRst_reg;
  reg [4:0]  cnt_reg;
  reg [23:0] rx_reg, sTx_reg;
  reg [15:0] outBuf_reg, inWord_reg;
  reg [7:0]  outCrc_reg;

  wire [4:0]  frameLen = cfgCrcEn ? `MHSP_SPI_LEN_CRC : `MHSP_SPI_LEN_PLAIN;
  wire [15:0] rxWord   = cfgCrcEn ? rx_reg[23:8] : rx_reg[15:0];
  wire [7:0]  rxCrc    = crc8(crc8(`MHSP_CRC_INIT, rxWord[15:8]), rxWord[7:0]);
  wire [7:0]  ldCrc    = crc8(crc8(`MHSP_CRC_INIT, spiOutWord[15:8]),
                              spiOutWord[7:0]);
  wire [23:0] startTx  = !oscRdy ? `MHSP_SPI_NOOSC // [RULE_17]
    : fresh_reg ? {outBuf_reg, outCrc_reg}
    : {`MHSP_SPI_ONES, `MHSP_SPI_STALE_CRC}; // [RULE_25]

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      csD_reg <= 1'b1;        sclkD_reg <= 1'b0;     on_reg <= 1'b0;
      miso_reg <= 1'b1;       fresh_reg <= 1'b0;     inVal_reg <= 1'b0;
      frErr_reg <= 1'b0;      crcErr_reg <= 1'b0;    spiRst_reg <= 1'b0;
      cnt_reg <= 5'd0;        rx_reg <= 24'h0;       sTx_reg <= 24'hFFFFFF;
      outBuf_reg <= 16'hFFFF; inWord_reg <= 16'h0;   outCrc_reg <= 8'h00;
      stallCnt_reg <= 32'h0;
    end else begin
      csD_reg    <= csS;
      sclkD_reg  <= sclkS;
      inVal_reg  <= 1'b0;
      frErr_reg  <= 1'b0;
      crcErr_reg <= 1'b0;
      spiRst_reg <= 1'b0;
      if (csS || sclkS != sclkD_reg || !on_reg)
        stallCnt_reg <= 32'h0;
      else
        stallCnt_reg <= stallCnt_reg + 32'd1;
      if (!spiRun || stallCnt_reg >= STALL_CYC) begin
        on_reg     <= 1'b0; // [RULE_21]
        spiRst_reg <= spiRun;
      end else if (csFall) begin
        on_reg    <= 1'b1;
        cnt_reg   <= 5'd0;
        sTx_reg   <= startTx;
        miso_reg  <= startTx[23]; // [RULE_14]
        fresh_reg <= 1'b0;
      end else if (on_reg && csRise) begin
        on_reg <= 1'b0;
        if (cnt_reg != frameLen) begin
          frErr_reg <= 1'b1; // [RULE_15]
        end else if (cfgCrcEn && rxCrc != rx_reg[7:0]) begin
          crcErr_reg <= 1'b1; // [RULE_24]
          outBuf_reg <= `MHSP_SPI_ONES; // [RULE_16]
          outCrc_reg <= `MHSP_SPI_CRC_ERR;
          fresh_reg  <= 1'b1;
        end else if (rxWord != `MHSP_SPI_ONES) begin // [RULE_19]
          inVal_reg  <= 1'b1; // [RULE_23]
          inWord_reg <= rxWord;
        end
      end else if (on_reg && sclkS && !sclkD_reg) begin
        rx_reg  <= {rx_reg[22:0], mosiS}; // [RULE_14]
        cnt_reg <= (cnt_reg == 5'd31) ? cnt_reg : cnt_reg + 5'd1;
      end else if (on_reg && !sclkS && sclkD_reg) begin
        sTx_reg  <= {sTx_reg[22:0], 1'b1};
        miso_reg <= sTx_reg[22]; // [RULE_14]
      end
      if (spiOutLoad && !(on_reg && csRise)) begin
        outBuf_reg <= spiOutWord;
        outCrc_reg <= ldCrc; // [RULE_08]
        fresh_reg  <= 1'b1;
      end
    end
  end

  assign spiMiso     = miso_reg;
  assign spiMisoOe   = on_reg;
  assign spiInValid  = inVal_reg;
  assign spiInWrite  = inWord_reg[15];
  assign spiInAddr   = inWord_reg[14:8];
  assign spiInData   = inWord_reg[7:0];
  assign spiFrameErr = frErr_reg;
  assign spiCrcErr   = crcErr_reg;
  assign spiBusReset = spiRst_reg;

endmodule

// >>> verif/mhsp_serial_port_sva.sv
/*
  Checker for the host serial port, bound to mhsp_serial_port.
  Assumes the top module's ports only; pins are raw, outputs registered.
*/
`timescale 1ns/1ps
module mhsp_serial_port_sva #(
  parameter STALL_CYC = 400000000,
  parameter SEC_CYC   = 200000000
) (
  input wire       ref_clk,
  input wire       rst_b,
  input wire       spiCs_b,
  input wire       spiSclk,
  input wire       spiMisoOe,
  input wire       oscRequest,
  input wire       activeSpi,
  input wire       i2cSdaOe,
  input wire       spiInValid,
  input wire       spiInWrite,
  input wire [6:0] spiInAddr,
  input wire [7:0] spiInData,
  input wire       spiFrameErr,
  input wire       spiCrcErr,
  input wire       spiBusReset
);
  int   csHighCnt;
  int   stillCnt;
  logic sclkLast;
  // ***********************************************************
  // cycles with select high, cycles of frozen clock in a frame
  // ***********************************************************
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      csHighCnt <= 0;
      stillCnt  <= 0;
      sclkLast  <= 1'b0;
    end else begin
      sclkLast  <= spiSclk;
      csHighCnt <= spiCs_b ? csHighCnt + 1 : 0;
      stillCnt  <= (spiCs_b || spiSclk != sclkLast) ? 0 : stillCnt + 1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence sCsFall;
    $fell(spiCs_b);
  endsequence
  sequence sFrameTaken;
    spiInValid;
  endsequence
  a_taken_after_rise: assert property (sFrameTaken |-> spiCs_b && $past(spiCs_b, 2))
    else $error("frame taken while select low");
  a_no_ones_write: assert property (sFrameTaken |-> !(spiInWrite && spiInAddr == 7'h7F && spiInData == 8'hFF))
    else $error("all ones frame taken");
  a_err_drops_data: assert property ((spiCrcErr || spiFrameErr) |-> !spiInValid)
    else $error("errored frame taken");
  a_miso_released: assert property (csHighCnt >= 60 |-> !spiMisoOe)
    else $error("miso driven outside frame");
  a_osc_wake: assert property (sCsFall |-> ##[1:60] oscRequest)
    else $error("select fall did not wake oscillator");
  a_osc_hold_time: assert property ($fell(oscRequest) |-> spiCs_b && csHighCnt >= SEC_CYC)
    else $error("oscillator released early");
  a_stall_reset: assert property (spiBusReset |-> stillCnt >= STALL_CYC)
    else $error("bus reset without full stall");
  a_two_wire_quiet: assert property (activeSpi && $past(activeSpi, 2) |-> !i2cSdaOe)
    else $error("two-wire pin driven in four-wire mode");
endmodule
bind mhsp_serial_port mhsp_serial_port_sva
  #(.STALL_CYC(STALL_CYC), .SEC_CYC(SEC_CYC)) mhsp_serial_port_sva_i (.*);

// >>> verif/mhsp_host_model.sv
/*
  Host master on the four-wire bus, mode 0, 80 ns link clock.
  Assumes the bench calls frame() with select idle high.
*/
`timescale 1ns/1ps
module mhsp_host_model (
  output logic sclk,
  output logic csB,
  output logic mosi,
  input  wire  miso
);
  initial begin
    sclk = 1'b0;
    csB  = 1'b1;
    mosi = 1'b0;
  end
  // clock idles low, data set while low, sampled at rise
  task automatic frame(input logic [23:0] tx, input int nBits,
                       input int holdNs, output logic [23:0] rx);
    rx  = 24'h000000;
    csB = 1'b0;
    #(holdNs);
    for (int i = 0; i < nBits; i++) begin
      mosi = tx[23 - i]; // msb first, crc byte last
      #40 sclk = 1'b1;
      rx = {rx[22:0], miso};
      #40 sclk = 1'b0;
    end
    #40 csB = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// >>> verif/mhsp_serial_port_tb_top.sv
/*
  Bench for the host serial port: protocol swap, speed update and
  four-wire frames. Assumes the host model drives the four-wire pins.
*/
`timescale 1ns/1ps
module mhsp_serial_port_tb_top;
  logic ref_clk = 1'b0, rst_b = 1'b0, cfgProtoSpi, cfgFastMode, cfgTimeoutEn;
  logic cfgAddrOverride, cfgCrcEn, cfgMisoAux, cfgUpdateMode;
  logic i2cScl = 1'b1, i2cSdaIn = 1'b1, input_filter_enable = 1'b0;
  logic switch_to_four_wire_cmd, switch_to_two_wire_cmd = 1'b0;
  logic oscRunning, spiOutLoad, gotValid, gotFrame, gotCrc, gotStall;
  logic [7:0] cfgSlaveAddr, cfgIdleTime, regRdData;
  logic [15:0] spiOutWord, w;
  logic [23:0] rx;
  wire spiSclk, spiCs_b, spiMosi, spiMiso, oscRequest, activeSpi;
  wire fastModeActive, i2cSdaOut, i2cSdaOe, spiMisoOe, regRdStb, regWrStb;
  wire output_from_aux_regulator, i2cBusReset;
  wire spiInValid, spiInWrite, spiFrameErr, spiCrcErr, spiBusReset;
  wire [6:0] spiInAddr;
  wire [7:0] spiInData, regAddr, regWrData;
  int fail_count = 0, n_compared = 0, seed = 65880;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (spiInValid) gotValid <= 1'b1;
    if (spiFrameErr) gotFrame <= 1'b1;
    if (spiCrcErr) gotCrc <= 1'b1;
    if (spiBusReset) gotStall <= 1'b1;
  end
  mhsp_host_model mhsp_host_model_i (.sclk(spiSclk), .csB(spiCs_b), .mosi(spiMosi), .miso(spiMiso));
  mhsp_serial_port #(.LONG_CYC(2000), .LOW100_CYC(600), .EXT100_CYC(400),
    .LOW400_CYC(300), .STALL_CYC(2000), .SEC_CYC(500), .WAKE_CYC(50))
    mhsp_serial_port_i (.*);
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [23:0] tx, input int n, input logic [23:0] exp);
    {gotValid, gotFrame, gotCrc, gotStall} = 4'h0;
    mhsp_host_model_i.frame(tx, n, 40, rx);
    repeat (12) tick;
    chk(rx, exp);
  endtask
  initial begin
    {cfgProtoSpi, cfgUpdateMode, oscRunning, spiOutLoad} = 4'h0;
    switch_to_four_wire_cmd = 1'b0;
    {cfgFastMode, cfgCrcEn, cfgIdleTime, spiOutWord} = {2'b11, 8'h00, 16'h0000};
    {cfgTimeoutEn, cfgAddrOverride, cfgMisoAux} = $random(seed);
    {cfgSlaveAddr, regRdData} = $random(seed);
    repeat (20) tick;
    rst_b = 1'b1;
    repeat (2) tick;
    cfgUpdateMode = 1'b1;
    {cfgProtoSpi, cfgFastMode} = 2'b10;
    repeat (4) tick;
    chk(fastModeActive, 1'b1);
    cfgUpdateMode = 1'b0;
    repeat (4) tick;
    chk({fastModeActive, activeSpi}, 2'b00);
    switch_to_four_wire_cmd = 1'b1;
    tick;
    switch_to_four_wire_cmd = 1'b0;
    repeat (3) tick;
    chk(activeSpi, 1'b1);
    xfer({16'h0500, crc8(16'h0500)}, 24, 24'hFFFFFF);
    chk(oscRequest, 1'b1);
    oscRunning = 1'b1;
    repeat (100) tick;
    for (int k = 0; k < 6; k++) begin
      w = $random(seed);
      if (w == 16'hFFFF) w = 16'h0000;
      spiOutWord = $random(seed);
      spiOutLoad = k[0];
      tick;
      spiOutLoad = 1'b0;
      xfer({w, crc8(w)}, 24, k[0] ? {spiOutWord, crc8(spiOutWord)} : 24'hFFFF00);
      chk({gotValid, spiInWrite, spiInAddr, spiInData}, {1'b1, w});
    end
    xfer({16'h9A3C, crc8(16'h9A3C) ^ 8'h5A}, 24, 24'hFFFF00);
    chk({gotCrc, gotValid}, 2'b10);
    xfer({16'h1200, crc8(16'h1200)}, 24, 24'hFFFFAA);
    xfer({16'hFFFF, crc8(16'hFFFF)}, 24, 24'hFFFF00);
    chk(gotValid, 1'b0);
    xfer({16'h8811, crc8(16'h8811)}, 16, 24'h00FFFF);
    chk({gotFrame, gotValid}, 2'b10);
    input_filter_enable = 1'b1;
    mhsp_host_model_i.frame(24'h000000, 0, 12000, rx);
    repeat (12) tick;
    chk({gotStall, oscRequest}, 2'b11);
    repeat (600) tick;
    chk(oscRequest, 1'b0);
    chk({i2cSdaOe, i2cBusReset, regWrStb}, 3'b000);
    switch_to_two_wire_cmd = 1'b1;
    tick;
    switch_to_two_wire_cmd = 1'b0;
    repeat (3) tick;
    chk(activeSpi, 1'b0);
    end_sim;
  end
  initial begin
    #300000;
    fail_count++;
    end_sim;
  end
endmodule
